//--- rtl/pss_sequencer.sv
`timescale 1ns/1ns
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int TENTH_CLKS = TENTH_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        run_term_i,
  input  wire logic        fwd_rev_term_i,
  input  wire logic [1:0]  ramp_term_i,
  input  wire logic        power_fail_i,
  output logic             running_o,
  output logic             reverse_o,
  output logic [1:0]       ramp_set_o,
  output logic [3:0]       stage_o,
  output logic             seq_done_o
);

  if (TENTH_CLKS < 2) begin : g_chk
    $error("TENTH_CLKS must be at least 2");
  end

  typedef struct packed {
    pss_term_t               sync1;
    pss_term_t               sync2;
    logic                    pf_d;
    logic [15:0]             mode;
    logic [15:0]             climit;
    logic [15:0]             retain;
    logic [15:0]             tbase;
    logic [15:0]             ctrl;
    logic [NSTAGE-1:0][15:0] set;
    logic [NSTAGE-1:0][15:0] dur;
    pss_fsm_t                fsm;
    pss_prog_t               live;
    pss_prog_t               saved;
    logic                    first_run;
    logic [31:0]             pre;
    logic [5:0]              sub;
    logic                    ack;
    logic [31:0]             dat;
    logic                    running;
    logic                    reverse;
    logic [1:0]              ramp;
    logic                    done;
  } pss_st_t;

  pss_st_t st;
  pss_st_t next_st;

  logic [NSTAGE:1] nz;
  logic [3:0]      first_v;
  logic [3:0]      last_v;
  logic [3:0]      next_v;
  logic [3:0]      resume_v;
  logic            run_cmd;
  logic            tick;
  logic            sw_req;
  logic [5:0]      widx;
  logic [3:0]      eidx;
  logic [15:0]     stage_set_sel;
  logic [15:0]     cur_dur;
  logic [15:0]     wv;
  logic [15:0]     rv;
  logic [15:0]     cyc_inc;
  logic            use_saved;

  for (genvar g = 1; g <= NSTAGE; g++) begin : g_nz
    assign nz[g] = st.dur[g-1] != 16'h0000;
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  always_comb begin
    first_v  = 4'h0;
    last_v   = 4'h0;
    next_v   = 4'h0;
    resume_v = 4'h0;
    for (int i = NSTAGE; i >= 1; i--) begin
      if (nz[i]) begin
        first_v = 4'(i);
      end
      if (nz[i] && 4'(i) > st.live.stage) begin
        next_v = 4'(i);
      end
      if (nz[i] && 4'(i) >= st.saved.stage) begin
        resume_v = 4'(i);
      end
    end
    for (int i = 1; i <= NSTAGE; i++) begin
      if (nz[i]) begin
        last_v = 4'(i);
      end
    end
  end

  // Sequencer run and stop come from the configured source only; direct mode follows the terminal run; the terminal path is synchronised.
  assign run_cmd = st.ctrl[CTRL_SRC_BIT] ? st.sync2.run : st.ctrl[CTRL_SOFT_RUN];
  assign cur_dur = (st.live.stage == 4'h0) ? 16'h0000 : st.dur[4'(st.live.stage - 4'h1)];
  assign cyc_inc = st.live.cyc + 16'h0001;
  assign use_saved = st.first_run ? st.retain[RET_PWR_BIT] : st.retain[RET_STOP_BIT];

  // The prescaler gives one pulse per tenth of a second; minute base divides that by sixty.
  always_comb begin
    tick = 1'b0;
    if (st.pre == 32'(TENTH_CLKS - 1)) begin
      tick = st.tbase[0] ? (st.sub == TENTHS_PER_MIN_TENTH) : 1'b1;
    end
  end

  assign sw_req = wb_cyc_i && wb_stb_i && !st.ack;
  assign widx   = wb_adr_i[7:2];
  assign eidx   = 4'((widx - ADR_STAGE_LO) >> 1);

  always_comb begin
    rv = 16'h0000;
    unique case (widx)
      ADR_MODE:     rv = st.mode;
      ADR_CLIMIT:   rv = st.climit;
      ADR_RETAIN:   rv = st.retain;
      ADR_TBASE:    rv = st.tbase;
      ADR_CTRL:     rv = st.ctrl;
      ADR_STATUS:   rv = {st.live.stage, st.ramp, st.reverse, st.done, st.fsm, st.running, 5'h00};
      ADR_SAV_CYC:  rv = st.saved.cyc;
      ADR_SAV_STG:  rv = {12'h000, st.saved.stage};
      ADR_SAV_ELP:  rv = st.saved.elapsed;
      ADR_LIVE_CYC: rv = st.live.cyc;
      default: begin
        if (widx >= ADR_STAGE_LO && widx <= ADR_STAGE_HI) begin
          rv = widx[0] ? st.dur[eidx] : st.set[eidx];
        end
      end
    endcase
  end

  always_comb begin
    next_st       = st;
    next_st.sync1 = '{run: run_term_i, fwd_rev: fwd_rev_term_i, ramp: ramp_term_i, pwr_fail: power_fail_i};
    next_st.sync2 = st.sync1;
    next_st.pf_d  = st.sync2.pwr_fail;
    next_st.ack   = sw_req;
    next_st.dat   = 32'h0000_0000;
    wv            = 16'h0000;

    if (sw_req && !wb_we_i) begin
      next_st.dat = {16'h0000, rv};
    end
    if (sw_req && wb_we_i) begin
      unique case (widx)
        ADR_MODE: begin
          wv           = merge16(st.mode, wb_dat_i, wb_sel_i);
          next_st.mode = {14'h0000, wv[1:0]};
        end
        ADR_CLIMIT: begin
          wv = merge16(st.climit, wb_dat_i, wb_sel_i);
          // Out-of-range limits are clamped so a bounded mode can never run forever.
          next_st.climit = (wv == 16'h0000) ? CLIMIT_RST : (wv > CLIMIT_MAX ? CLIMIT_MAX : wv);
        end
        ADR_RETAIN:  next_st.retain = merge16(st.retain, wb_dat_i, wb_sel_i) & 16'h0011;
        ADR_TBASE:   next_st.tbase  = merge16(st.tbase, wb_dat_i, wb_sel_i) & 16'h0001;
        ADR_CTRL:    next_st.ctrl   = merge16(st.ctrl, wb_dat_i, wb_sel_i) & 16'h0017;
        ADR_SAV_CYC: next_st.saved.cyc = merge16(st.saved.cyc, wb_dat_i, wb_sel_i);
        ADR_SAV_STG: begin
          wv                  = merge16({12'h000, st.saved.stage}, wb_dat_i, wb_sel_i);
          next_st.saved.stage = wv[3:0];
        end
        ADR_SAV_ELP: next_st.saved.elapsed = merge16(st.saved.elapsed, wb_dat_i, wb_sel_i);
        ADR_STATUS, ADR_LIVE_CYC: begin
        end
        default: begin
          if (widx >= ADR_STAGE_LO && widx <= ADR_STAGE_HI) begin
            if (widx[0]) begin
              wv = merge16(st.dur[eidx], wb_dat_i, wb_sel_i);
              next_st.dur[eidx] = (wv > DUR_MAX) ? DUR_MAX : wv;
            end else begin
              next_st.set[eidx] = merge16(st.set[eidx], wb_dat_i, wb_sel_i) & 16'h0031;
            end
          end
        end
      endcase
    end

    // Power-loss snapshot; software copies it to non-volatile store and back after power-up.
    if (st.sync2.pwr_fail && !st.pf_d && st.retain[RET_PWR_BIT] &&
        (st.fsm == PSS_RUN || st.fsm == PSS_HOLD)) begin
      next_st.saved = st.live;
    end

    if (st.fsm == PSS_RUN) begin
      next_st.pre = (st.pre == 32'(TENTH_CLKS - 1)) ? 32'h0000_0000 : st.pre + 32'h0000_0001;
      if (st.pre == 32'(TENTH_CLKS - 1)) begin
        next_st.sub = (st.sub == TENTHS_PER_MIN_TENTH) ? 6'h00 : st.sub + 6'h01;
      end
    end else begin
      next_st.pre = 32'h0000_0000;
      next_st.sub = 6'h00;
    end

    unique case (st.fsm)
      PSS_IDLE: begin
        if (run_cmd && st.ctrl[CTRL_SEQ_EN]) begin
          next_st.first_run = 1'b0;
          if (first_v == 4'h0) begin
            next_st.fsm = PSS_DONE;
          end else if (use_saved && resume_v != 4'h0) begin
            next_st.fsm          = PSS_RUN;
            next_st.live.cyc     = st.saved.cyc;
            next_st.live.stage   = resume_v;
            next_st.live.elapsed = (resume_v == st.saved.stage) ? st.saved.elapsed : 16'h0000;
          end else begin
            next_st.fsm  = PSS_RUN;
            next_st.live = '{cyc: 16'h0000, stage: first_v, elapsed: 16'h0000};
          end
        end
      end
      PSS_RUN: begin
        if (!run_cmd) begin
          next_st.fsm = PSS_IDLE;
          if (st.retain[RET_STOP_BIT]) begin
            next_st.saved = st.live;
          end
        end else if (cur_dur == 16'h0000) begin
          // A duration cleared while running skips at once to the next nonzero stage, wrapping to the first without counting a cycle.
          next_st.live.elapsed = 16'h0000;
          next_st.live.stage   = (next_v == 4'h0) ? first_v : next_v;
          if (first_v == 4'h0) begin
            next_st.fsm = PSS_DONE;
          end
        end else if (tick) begin
          if (st.live.elapsed + 16'h0001 < cur_dur) begin
            next_st.live.elapsed = st.live.elapsed + 16'h0001;
          end else if (next_v != 4'h0 && st.live.stage != last_v) begin
            next_st.live.stage   = next_v;
            next_st.live.elapsed = 16'h0000;
          end else begin
            next_st.live.cyc     = cyc_inc;
            next_st.live.elapsed = 16'h0000;
            unique case (st.mode[1:0])
              MODE_ONCE: begin
                next_st.fsm = PSS_DONE;
              end
              MODE_LIMITED: begin
                if (cyc_inc >= st.climit) begin
                  next_st.fsm = PSS_DONE;
                end else begin
                  next_st.live.stage = first_v;
                end
              end
              MODE_HOLDLAST: begin
                if (cyc_inc >= st.climit) begin
                  next_st.fsm = PSS_HOLD;
                end else begin
                  next_st.live.stage = first_v;
                end
              end
              MODE_LOOP: begin
                next_st.live.cyc   = st.live.cyc;
                next_st.live.stage = first_v;
              end
            endcase
          end
        end
      end
      PSS_HOLD: begin
        if (!run_cmd) begin
          next_st.fsm = PSS_IDLE;
          // The sequence is complete, so a later start begins from the first stage with a nonzero duration.
          next_st.saved = '0;
        end
      end
      PSS_DONE: begin
        next_st.saved = '0;
        if (!run_cmd) begin
          next_st.fsm = PSS_IDLE;
        end
      end
    endcase

    // With CTRL_SEQ_EN set, direction and ramp follow the stage being entered, so they do not lag stage_o by a cycle; CTRL_RAMP_TRM takes ramp from the terminal.
    stage_set_sel = (next_st.live.stage == 4'h0) ? SET_RST : st.set[4'(next_st.live.stage - 4'h1)];
    if (st.ctrl[CTRL_SEQ_EN]) begin
      next_st.running = (next_st.fsm == PSS_RUN) || (next_st.fsm == PSS_HOLD);
      next_st.reverse = stage_set_sel[SET_DIR_BIT];
      next_st.ramp    = stage_set_sel[SET_RAMP_LSB +: 2];
    end else begin
      next_st.running = st.sync2.run;
      next_st.reverse = st.sync2.run && st.sync2.fwd_rev;
      next_st.ramp    = 2'h0;
    end
    if (st.ctrl[CTRL_RAMP_TRM]) begin
      next_st.ramp = st.sync2.ramp;
    end
    next_st.done = (st.fsm == PSS_DONE) || (st.fsm == PSS_HOLD);

    if (rst_i) begin
      next_st           = '0;
      next_st.mode      = MODE_RST;
      next_st.climit    = CLIMIT_RST;
      next_st.retain    = RETAIN_RST;
      next_st.tbase     = TBASE_RST;
      next_st.set       = {NSTAGE{SET_RST}};
      next_st.dur       = {NSTAGE{DUR_RST}};
      next_st.fsm       = PSS_IDLE;
      next_st.first_run = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign wb_dat_o   = st.dat;
  assign wb_ack_o   = st.ack;
  assign running_o  = st.running;
  assign reverse_o  = st.reverse;
  assign ramp_set_o = st.ramp;
  assign stage_o    = st.live.stage;
  assign seq_done_o = st.done;

endmodule // pss_sequencer

//--- rtl/pss_pkg.sv
package pss_pkg;

  localparam int          DW            = 16;
  localparam int          NSTAGE        = 15;
  localparam int          CLK_PERIOD_NS = 20;
  // Stage durations count in tenths of the selected time base.
  localparam int          TENTH_SEC_NS  = 100_000_000;
  localparam int          TENTH_CYCLES  = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  TENTHS_PER_MIN_TENTH = 6'h3b;

  // Word addresses: byte address bits [7:2].
  localparam logic [5:0]  ADR_MODE      = 6'h00;
  localparam logic [5:0]  ADR_CLIMIT    = 6'h01;
  localparam logic [5:0]  ADR_RETAIN    = 6'h02;
  localparam logic [5:0]  ADR_TBASE     = 6'h03;
  localparam logic [5:0]  ADR_CTRL      = 6'h04;
  localparam logic [5:0]  ADR_STATUS    = 6'h05;
  localparam logic [5:0]  ADR_SAV_CYC   = 6'h06;
  localparam logic [5:0]  ADR_SAV_STG   = 6'h07;
  localparam logic [5:0]  ADR_SAV_ELP   = 6'h08;
  localparam logic [5:0]  ADR_LIVE_CYC  = 6'h09;
  localparam logic [5:0]  ADR_STAGE_LO  = 6'h10;
  localparam logic [5:0]  ADR_STAGE_HI  = 6'h2d;

  localparam logic [15:0] MODE_RST      = 16'h0000;
  localparam logic [15:0] CLIMIT_RST    = 16'h0001;
  localparam logic [15:0] CLIMIT_MAX    = 16'h2710;
  localparam logic [15:0] RETAIN_RST    = 16'h0000;
  localparam logic [15:0] TBASE_RST     = 16'h0000;
  localparam logic [15:0] SET_RST       = 16'h0000;
  localparam logic [15:0] DUR_RST       = 16'h0032;
  localparam logic [15:0] DUR_MAX       = 16'hea60;

  // Field positions within the registers; numeric values are plain binary.
  localparam int          RET_STOP_BIT  = 0;
  localparam int          RET_PWR_BIT   = 4;
  localparam int          SET_DIR_BIT   = 0;
  localparam int          SET_RAMP_LSB  = 4;
  localparam int          CTRL_SEQ_EN   = 0;
  localparam int          CTRL_SOFT_RUN = 1;
  localparam int          CTRL_RAMP_TRM = 2;
  localparam int          CTRL_SRC_BIT  = 4;

  localparam logic [1:0]  MODE_ONCE     = 2'h0;
  localparam logic [1:0]  MODE_LIMITED  = 2'h1;
  localparam logic [1:0]  MODE_HOLDLAST = 2'h2;
  localparam logic [1:0]  MODE_LOOP     = 2'h3;

  typedef enum logic [1:0] {
    PSS_IDLE = 2'b00,
    PSS_RUN  = 2'b01,
    PSS_HOLD = 2'b11,
    PSS_DONE = 2'b10
  } pss_fsm_t;

  typedef struct packed {
    logic       run;
    logic       fwd_rev;
    logic [1:0] ramp;
    logic       pwr_fail;
  } pss_term_t;

  typedef struct packed {
    logic [15:0] cyc;
    logic [3:0]  stage;
    logic [15:0] elapsed;
  } pss_prog_t;

endpackage

//--- sim/pss_props.sv
`timescale 1ns/1ns
module pss_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        running_o,
  input wire logic        reverse_o,
  input wire logic [1:0]  ramp_set_o,
  input wire logic [3:0]  stage_o,
  input wire logic        seq_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow a request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read data not zero");
  out_reset_a: assert property ($past(rst_i) |-> !running_o && !reverse_o && ramp_set_o == 2'h0
    && stage_o == 4'h0 && !seq_done_o)
    else $error("outputs not clear after reset");
  // Durations under test are long enough that no legal stage lasts under four cycles.
  stage_dwell_a: assert property ($changed(stage_o) && stage_o != 4'h0 |=> $stable(stage_o) [*3])
    else $error("stage left too soon");
  done_after_a: assert property ($rose(seq_done_o) |-> $past(stage_o) != 4'h0)
    else $error("finished without a stage");
endmodule // pss_props

//--- sim/pss_term_model.sv
`timescale 1ns/1ns
// Control panel: pins follow the request LAG edges later, as a slow panel would.
module pss_term_model
  import pss_pkg::*;
#(
  parameter int LAG = 1
) (
  input  wire pss_term_t req_i,
  input  wire logic      clk_i,
  output pss_term_t      pins_o
);
  pss_term_t pipe [LAG] = '{default: '0};
  always @(posedge clk_i) begin
    pipe[0] <= req_i;
    for (int i = 1; i < LAG; i++) pipe[i] <= pipe[i-1];
  end
  assign pins_o = pipe[LAG-1];
endmodule // pss_term_model

//--- sim/pss_sequencer_test.sv
`timescale 1ns/1ns
bind pss_sequencer pss_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
  .running_o, .reverse_o, .ramp_set_o, .stage_o, .seq_done_o);
module pss_sequencer_test;
  import pss_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = '0, dat = '0, wb_dat_o;
  logic [3:0]  sel = '0, stage_o, last_stage = '0;
  logic        wb_ack_o, running_o, reverse_o, seq_done_o;
  logic [1:0]  ramp_set_o;
  pss_term_t   req = '0, pins;
  int          miscompares = 0, check_count = 0;
  logic [31:0] rdq [$];
  logic [6:0]  stq [$];
  logic [15:0] setv [1:15];
  always #10 clk_i = ~clk_i;
  pss_term_model #(.LAG(2)) u_term (.req_i(req), .clk_i(clk_i), .pins_o(pins));
  pss_sequencer #(.TENTH_CLKS(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .run_term_i(pins.run), .fwd_rev_term_i(pins.fwd_rev), .ramp_term_i(pins.ramp),
    .power_fail_i(pins.pwr_fail), .running_o(running_o), .reverse_o(reverse_o), .ramp_set_o(ramp_set_o),
    .stage_o(stage_o), .seq_done_o(seq_done_o));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up(string n);
    $display("ERROR %s expected response seen timeout", n);
    miscompares++;
    tally_and_finish;
  endtask
  task automatic cyc_n(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(logic w, logic [5:0] a, logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {24'h0, a, 2'h0};
    dat <= {16'h0, d};
    sel <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) give_up("wb_ack_o");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(logic [5:0] a, logic [15:0] e);
    rdq.push_back({16'h0, e});
    wb(1'b0, a, 16'h0);
  endtask
  task automatic prog(logic [15:0] mask);
    for (int n = 1; n <= 15; n++) begin
      setv[n] = 16'((($urandom % 4) << 4) | ($urandom % 2));
      wb(1'b1, 6'h10 + 6'(2 * n - 2), setv[n]);
      wb(1'b1, 6'h11 + 6'(2 * n - 2), mask[n] ? 16'(4 + $urandom % 3) : 16'h0);
    end
  endtask
  task automatic plan_seq(logic [15:0] mask, int reps);
    repeat (reps)
      for (int n = 1; n <= 15; n++)
        if (mask[n]) stq.push_back({4'(n), setv[n][0], setv[n][5:4]});
  endtask
  task automatic wait_q(logic want_done);
    int n;
    for (n = 0; n < 4000 && (stq.size() != 0 || seq_done_o !== want_done); n++) @(posedge clk_i);
    if (n == 4000) give_up("sequence");
  endtask
  task automatic run(logic v);
    req.run <= v;
    cyc_n(8);
  endtask
  // Reset leaves stage_o at zero and a stop holds it, so only a new nonzero stage counts as a result.
  always @(posedge clk_i) begin
    if (!rst_i) begin
      if (wb_ack_o === 1'b1 && !we) chk("wb_dat_o", wb_dat_o, rdq.pop_front());
      if (stage_o !== 4'h0 && stage_o !== last_stage) begin
        if (stq.size() == 0) chk("stage_o", 32'(stage_o), 32'h0);
        else chk("stage", {25'h0, stage_o, reverse_o, ramp_set_o}, {25'h0, stq.pop_front()});
        last_stage <= stage_o;
      end
    end
  end
  initial begin
    logic [1:0] r;
    void'($urandom(54));
    cyc_n(12);
    rst_i <= 1'b0;
    cyc_n(2);
    rd(ADR_MODE, MODE_RST);
    rd(ADR_CLIMIT, CLIMIT_RST);
    rd(ADR_RETAIN, RETAIN_RST);
    rd(ADR_TBASE, TBASE_RST);
    rd(6'h10, SET_RST);
    rd(6'h11, DUR_RST);
    wb(1'b1, ADR_CLIMIT, 16'h0);
    rd(ADR_CLIMIT, 16'h1);
    wb(1'b1, ADR_CLIMIT, 16'hffff);
    rd(ADR_CLIMIT, CLIMIT_MAX);
    wb(1'b1, 6'h11, 16'hffff);
    rd(6'h11, DUR_MAX);
    wb(1'b1, ADR_STATUS, 16'hffff);
    rd(ADR_STATUS, 16'h0);
    wb(1'b1, 6'h3f, 16'h1234);
    rd(6'h3f, 16'h0);
    r = 2'($urandom % 4);
    wb(1'b1, ADR_CTRL, 16'h14);
    req <= '{run: 1'b1, fwd_rev: 1'b1, ramp: r, pwr_fail: 1'b0};
    cyc_n(8);
    chk("reverse_o", 32'(reverse_o), 32'h1);
    chk("ramp_set_o", 32'(ramp_set_o), 32'(r));
    req.fwd_rev <= 1'b0;
    run(1'b0);
    chk("running_o", 32'(running_o), 32'h0);
    prog(16'h3ff6);
    wb(1'b1, ADR_CTRL, 16'h11);
    plan_seq(16'h3ff6, 1);
    run(1'b1);
    wait_q(1'b1);
    chk("running_o", 32'(running_o), 32'h0);
    run(1'b0);
    prog(16'h0024);
    wb(1'b1, ADR_MODE, 16'(MODE_LIMITED));
    wb(1'b1, ADR_CLIMIT, 16'h2);
    plan_seq(16'h0024, 2);
    run(1'b1);
    wait_q(1'b1);
    chk("running_o", 32'(running_o), 32'h0);
    run(1'b0);
    wb(1'b1, ADR_MODE, 16'(MODE_HOLDLAST));
    plan_seq(16'h0024, 2);
    run(1'b1);
    wait_q(1'b1);
    chk("running_o", 32'(running_o), 32'h1);
    chk("stage_o", 32'(stage_o), 32'h5);
    run(1'b0);
    chk("running_o", 32'(running_o), 32'h0);
    wb(1'b1, ADR_MODE, 16'(MODE_LOOP));
    wb(1'b1, ADR_CTRL, 16'h13);
    cyc_n(8);
    chk("running_o", 32'(running_o), 32'h0);
    plan_seq(16'h0024, 3);
    wb(1'b1, ADR_CTRL, 16'h03);
    wait_q(1'b0);
    wb(1'b1, ADR_CTRL, 16'h01);
    cyc_n(8);
    chk("running_o", 32'(running_o), 32'h0);
    wb(1'b1, ADR_MODE, 16'(MODE_ONCE));
    wb(1'b1, ADR_CTRL, 16'h11);
    plan_seq(16'h0024, 1);
    run(1'b1);
    wait_q(1'b0);
    run(1'b0);
    plan_seq(16'h0024, 1);
    run(1'b1);
    wait_q(1'b1);
    run(1'b0);
    wb(1'b1, ADR_RETAIN, 16'h01);
    plan_seq(16'h0024, 1);
    run(1'b1);
    wait_q(1'b0);
    run(1'b0);
    rd(ADR_SAV_STG, 16'h5);
    run(1'b1);
    wait_q(1'b1);
    chk("running_o", 32'(running_o), 32'h0);
    run(1'b0);
    wb(1'b1, ADR_RETAIN, 16'h10);
    wb(1'b1, ADR_TBASE, 16'h1);
    plan_seq(16'h0024, 1);
    run(1'b1);
    cyc_n(100);
    chk("stage_o", 32'(stage_o), 32'h2);
    req.pwr_fail <= 1'b1;
    cyc_n(8);
    rd(ADR_SAV_STG, 16'h2);
    req.pwr_fail <= 1'b0;
    wait_q(1'b1);
    chk("running_o", 32'(running_o), 32'h0);
    tally_and_finish;
  end
endmodule // pss_sequencer_test
